// ---- pkg/usart_pkg.sv ----
/*
 Constants for the addressable serial transceiver: register offsets on the
 Wishbone bus, bit positions, reset values and baud oversampling ratios.
 Assumes a 32-bit classic Wishbone bus with one 8-bit register per word.
*/
package usart_pkg;
   // ----------------------------------------------------------------------
   // register byte offsets
   // ----------------------------------------------------------------------
   localparam logic [7:0] OFS_INTERRUPT_CONTROL = 8'h00;
   localparam logic [7:0] OFS_PERIPHERAL_FLAGS_ONE = 8'h04;
   localparam logic [7:0] OFS_PERIPHERAL_ENABLES_ONE = 8'h08;
   localparam logic [7:0] OFS_PERIPHERAL_PRIORITIES_ONE = 8'h0C;
   localparam logic [7:0] OFS_RECEIVE_STATUS_CONTROL = 8'h10;
   localparam logic [7:0] OFS_RECEIVE_DATA = 8'h14;
   localparam logic [7:0] OFS_TRANSMIT_STATUS_CONTROL = 8'h18;
   localparam logic [7:0] OFS_BAUD_DIVISOR = 8'h1C;
   localparam logic [7:0] OFS_TRANSMIT_DATA = 8'h20;
   // ----------------------------------------------------------------------
   // bit positions
   // ----------------------------------------------------------------------
   localparam int GLOBAL_INTERRUPT_ENABLE_BIT = 7;
   localparam int RECEIVE_BIT = 5;
   localparam int TRANSMIT_BIT = 4;
   localparam int SERIAL_PORT_ENABLE_BIT = 7;
   localparam int NINE_BIT_RECEIVE_BIT = 6;
   localparam int SINGLE_RECEIVE_BIT = 5;
   localparam int CONTINUOUS_RECEIVE_BIT = 4;
   localparam int ADDRESS_DETECT_BIT = 3;
   localparam int FRAMING_ERROR_BIT = 2;
   localparam int OVERRUN_ERROR_BIT = 1;
   localparam int RECEIVED_NINTH_BIT = 0;
   localparam int MASTER_CLOCK_SOURCE_BIT = 7;
   localparam int NINE_BIT_TRANSMIT_BIT = 6;
   localparam int TRANSMIT_ENABLE_BIT = 5;
   localparam int CLOCKED_MODE_BIT = 4;
   localparam int HIGH_SPEED_BAUD_BIT = 2;
   localparam int SHIFT_REGISTER_EMPTY_BIT = 1;
   localparam int TRANSMIT_NINTH_BIT = 0;
   // ----------------------------------------------------------------------
   // reset values and timing
   // ----------------------------------------------------------------------
   localparam logic [7:0] RESET_BYTE = 8'h00;
   localparam logic [7:0] TRANSMIT_STATUS_RESET = 8'h02;
   localparam logic [6:0] OVERSAMPLE_HIGH = 7'h10;
   localparam logic [6:0] OVERSAMPLE_LOW = 7'h40;
   localparam logic [3:0] BITS_EIGHT = 4'h8;
   localparam logic [3:0] BITS_NINE = 4'h9;
endpackage

// ---- logic/usart_core.sv ----
/*
 Addressable serial transceiver: asynchronous nine-bit reception with
 address detection and synchronous master transmission, registers on a
 classic Wishbone slave. Assumes pin pads resolve the enables into wires
 and that the data pin reaches this block through no other synchroniser.
*/
`timescale 1ns/1ps
module usart_core
   import usart_pkg::*;
(
   // clock and reset
   input wire logic REF_CLK,
   input wire logic RESET,
   // wishbone slave
   input wire logic CYC_I,
   input wire logic STB_I,
   input wire logic WE_I,
   input wire logic [7:0] ADR_I,
   input wire logic [3:0] SEL_I,
   input wire logic [31:0] DAT_I,
   output logic [31:0] DAT_O,
   output logic ACK_O,
   // shift timing line pin
   input wire logic SHIFT_TIMING_LINE_IN,
   output logic SHIFT_TIMING_LINE_OUT,
   output logic SHIFT_TIMING_LINE_OE,
   // serial data line pin
   input wire logic SERIAL_DATA_LINE_IN,
   output logic SERIAL_DATA_LINE_OUT,
   output logic SERIAL_DATA_LINE_OE,
   // interrupt requests by priority
   output logic INTERRUPT_HIGH,
   output logic INTERRUPT_LOW
);
   typedef enum logic [3:0] {
      RX_IDLE = 4'b0001,
      RX_START = 4'b0010,
      RX_DATA = 4'b0100,
      RX_STOP = 4'b1000
   } rx_state_t;
   typedef enum logic [2:0] {
      TX_IDLE = 3'b001,
      TX_LOW = 3'b010,
      TX_HIGH = 3'b100
   } tx_state_t;

   // ----------------------------------------------------------------------
   // registers
   // ----------------------------------------------------------------------
   logic [7:0] interrupt_control;
   logic [7:0] flags_other;
   logic [7:0] peripheral_enables_one;
   logic [7:0] peripheral_priorities_one;
   logic [7:0] rx_control;
   logic [7:0] tx_control;
   logic [7:0] baud_divisor;
   logic [7:0] transmit_data;
   logic [7:0] receive_data;
   logic receive_complete_flag;
   logic transmit_buffer_empty_flag;
   logic framing_error_flag;
   logic overrun_error_flag;
   logic received_ninth_bit;
   logic buffer_full;
   logic shift_register_empty;

   logic serial_port_enable;
   logic nine_bit_receive_enable;
   logic continuous_receive_enable;
   logic address_detect_enable;
   logic clocked_mode;
   logic master_clock_source;
   logic transmit_enable;
   logic high_speed_baud_select;
   assign serial_port_enable = rx_control[SERIAL_PORT_ENABLE_BIT];
   assign nine_bit_receive_enable = rx_control[NINE_BIT_RECEIVE_BIT];
   assign continuous_receive_enable = rx_control[CONTINUOUS_RECEIVE_BIT];
   assign address_detect_enable = rx_control[ADDRESS_DETECT_BIT];
   assign clocked_mode = tx_control[CLOCKED_MODE_BIT];
   assign master_clock_source = tx_control[MASTER_CLOCK_SOURCE_BIT];
   assign transmit_enable = tx_control[TRANSMIT_ENABLE_BIT];
   assign high_speed_baud_select = tx_control[HIGH_SPEED_BAUD_BIT];

   // ----------------------------------------------------------------------
   // wishbone slave
   // ----------------------------------------------------------------------
   // ack one cycle after the request; writes and read side effects happen
   // on the edge where ack is high, the edge the master samples it
   logic access;
   logic write_now;
   logic read_now;
   assign access = CYC_I && STB_I && ACK_O;
   assign write_now = access && WE_I && SEL_I[0];
   assign read_now = access && !WE_I;

   function automatic logic wr_hit(input logic [7:0] ofs);
      wr_hit = write_now && (ADR_I == ofs);
   endfunction

   logic [7:0] next_read;
   always_comb begin
      next_read = RESET_BYTE;
      case (ADR_I)
         OFS_INTERRUPT_CONTROL: next_read = interrupt_control;
         OFS_PERIPHERAL_FLAGS_ONE: begin
            next_read = flags_other;
            next_read[RECEIVE_BIT] = receive_complete_flag;
            next_read[TRANSMIT_BIT] = transmit_buffer_empty_flag;
         end
         OFS_PERIPHERAL_ENABLES_ONE: next_read = peripheral_enables_one;
         OFS_PERIPHERAL_PRIORITIES_ONE: next_read = peripheral_priorities_one;
         OFS_RECEIVE_STATUS_CONTROL: begin
            next_read = rx_control;
            next_read[FRAMING_ERROR_BIT] = framing_error_flag;
            next_read[OVERRUN_ERROR_BIT] = overrun_error_flag;
            next_read[RECEIVED_NINTH_BIT] = received_ninth_bit;
         end
         OFS_RECEIVE_DATA: next_read = receive_data;
         OFS_TRANSMIT_STATUS_CONTROL: begin
            next_read = tx_control;
            next_read[SHIFT_REGISTER_EMPTY_BIT] = shift_register_empty;
         end
         OFS_BAUD_DIVISOR: next_read = baud_divisor;
         OFS_TRANSMIT_DATA: next_read = transmit_data;
         default: next_read = RESET_BYTE;
      endcase
   end

   always_ff @(posedge REF_CLK or posedge RESET) begin
      if (RESET) begin
         ACK_O <= 1'b0;
         DAT_O <= 32'h0000_0000;
      end else begin
         ACK_O <= CYC_I && STB_I && !ACK_O;
         DAT_O <= {24'h00_0000, next_read};
      end
   end

   // plain control registers; status bits inside them are overlaid on read
   always_ff @(posedge REF_CLK or posedge RESET) begin
      if (RESET) begin
         interrupt_control <= RESET_BYTE;
         flags_other <= RESET_BYTE;
         peripheral_enables_one <= RESET_BYTE;
         peripheral_priorities_one <= RESET_BYTE;
         rx_control <= RESET_BYTE;
         tx_control <= TRANSMIT_STATUS_RESET;
         baud_divisor <= RESET_BYTE;
      end else begin
         if (wr_hit(OFS_INTERRUPT_CONTROL))
            interrupt_control <= DAT_I[7:0];
         if (wr_hit(OFS_PERIPHERAL_FLAGS_ONE))
            flags_other <= DAT_I[7:0];
         if (wr_hit(OFS_PERIPHERAL_ENABLES_ONE))
            peripheral_enables_one <= DAT_I[7:0];
         if (wr_hit(OFS_PERIPHERAL_PRIORITIES_ONE))
            peripheral_priorities_one <= DAT_I[7:0];
         if (wr_hit(OFS_RECEIVE_STATUS_CONTROL))
            rx_control <= DAT_I[7:0];
         if (wr_hit(OFS_TRANSMIT_STATUS_CONTROL))
            tx_control <= DAT_I[7:0];
         if (wr_hit(OFS_BAUD_DIVISOR))
            baud_divisor <= DAT_I[7:0];
      end
   end

   // ----------------------------------------------------------------------
   // baud generator
   // ----------------------------------------------------------------------
   // one tick every divisor+1 cycles; async oversamples 16 or 64 ticks per
   // bit, sync uses one tick per half period of the shift clock
   logic [7:0] baud_count;
   logic baud_tick;
   always_ff @(posedge REF_CLK or posedge RESET) begin
      if (RESET) begin
         baud_count <= RESET_BYTE;
         baud_tick <= 1'b0;
      end else if (baud_count == RESET_BYTE) begin
         baud_count <= baud_divisor;
         baud_tick <= 1'b1;
      end else begin
         baud_count <= baud_count - 8'h01;
         baud_tick <= 1'b0;
      end
   end

   logic [6:0] ticks_per_bit;
   logic [6:0] mid_tick;
   assign ticks_per_bit = high_speed_baud_select ? OVERSAMPLE_HIGH : OVERSAMPLE_LOW;
   assign mid_tick = {1'b0, ticks_per_bit[6:1]};

   // ----------------------------------------------------------------------
   // asynchronous receiver
   // ----------------------------------------------------------------------
   logic data_meta;
   logic data_sync;
   always_ff @(posedge REF_CLK or posedge RESET) begin
      if (RESET) begin
         data_meta <= 1'b1;
         data_sync <= 1'b1;
      end else begin
         data_meta <= SERIAL_DATA_LINE_IN;
         data_sync <= data_meta;
      end
   end

   rx_state_t rx_state;
   logic [6:0] rx_ticks;
   logic [3:0] rx_bits;
   logic [8:0] rx_shift;
   logic rx_done;
   logic rx_stop_bad;
   logic rx_active;
   logic tx_busy;
   // no reception in sync mode, and never while a word is going out
   assign rx_active = serial_port_enable && !clocked_mode && continuous_receive_enable
      && !overrun_error_flag && !tx_busy;

   always_ff @(posedge REF_CLK or posedge RESET) begin
      if (RESET) begin
         rx_state <= RX_IDLE;
         rx_ticks <= 7'h00;
         rx_bits <= 4'h0;
         rx_shift <= 9'h000;
         rx_done <= 1'b0;
         rx_stop_bad <= 1'b0;
      end else begin
         rx_done <= 1'b0;
         if (!rx_active) begin
            rx_state <= RX_IDLE;
         end else begin
            case (rx_state)
               RX_IDLE: begin
                  rx_ticks <= 7'h00;
                  rx_bits <= 4'h0;
                  if (!data_sync)
                     rx_state <= RX_START;
               end
               RX_START: begin
                  if (baud_tick) begin
                     rx_ticks <= rx_ticks + 7'h01;
                     if (rx_ticks == mid_tick && data_sync)
                        rx_state <= RX_IDLE;
                     else if (rx_ticks == ticks_per_bit - 7'h01) begin
                        rx_ticks <= 7'h00;
                        rx_state <= RX_DATA;
                     end
                  end
               end
               RX_DATA: begin
                  if (baud_tick) begin
                     rx_ticks <= rx_ticks + 7'h01;
                     if (rx_ticks == mid_tick)
                        rx_shift <= {data_sync, rx_shift[8:1]};
                     if (rx_ticks == ticks_per_bit - 7'h01) begin
                        rx_ticks <= 7'h00;
                        rx_bits <= rx_bits + 4'h1;
                        if (rx_bits == (nine_bit_receive_enable ? BITS_NINE : BITS_EIGHT)
                              - 4'h1)
                           rx_state <= RX_STOP;
                     end
                  end
               end
               RX_STOP: begin
                  if (baud_tick) begin
                     rx_ticks <= rx_ticks + 7'h01;
                     if (rx_ticks == mid_tick) begin
                        rx_done <= 1'b1;
                        rx_stop_bad <= !data_sync;
                        rx_state <= RX_IDLE;
                     end
                  end
               end
               default: rx_state <= RX_IDLE;
            endcase
         end
      end
   end

   // eight-bit words land in the top of the shifter
   logic [8:0] rx_word;
   logic rx_accept;
   assign rx_word = nine_bit_receive_enable ? rx_shift : {1'b0, rx_shift[8:1]};
   // address words carry a one in the ninth bit
   assign rx_accept = !(address_detect_enable && nine_bit_receive_enable
      && !rx_word[8]);

   logic rx_read;
   assign rx_read = read_now && (ADR_I == OFS_RECEIVE_DATA);

   always_ff @(posedge REF_CLK or posedge RESET) begin
      if (RESET) begin
         receive_data <= RESET_BYTE;
         received_ninth_bit <= 1'b0;
         framing_error_flag <= 1'b0;
      end else if (rx_done && rx_accept && !receive_complete_flag) begin
         receive_data <= rx_word[7:0];
         received_ninth_bit <= rx_word[8];
         framing_error_flag <= rx_stop_bad;
      end else if (!continuous_receive_enable) begin
         framing_error_flag <= 1'b0;
      end
   end

   // a new word in the same cycle as the read keeps the flag set
   always_ff @(posedge REF_CLK or posedge RESET) begin
      if (RESET)
         receive_complete_flag <= 1'b0;
      else if (rx_done && rx_accept)
         receive_complete_flag <= 1'b1;
      else if (rx_read)
         receive_complete_flag <= 1'b0;
   end

   // a word arriving while the last one is unread is lost and flagged
   always_ff @(posedge REF_CLK or posedge RESET) begin
      if (RESET)
         overrun_error_flag <= 1'b0;
      else if (!continuous_receive_enable)
         overrun_error_flag <= 1'b0;
      else if (rx_done && rx_accept && receive_complete_flag && !rx_read)
         overrun_error_flag <= 1'b1;
   end

   // ----------------------------------------------------------------------
   // synchronous master transmitter
   // ----------------------------------------------------------------------
   logic tx_on;
   logic tx_write;
   logic tx_load;
   logic tx_en_prev;
   tx_state_t tx_state;
   logic [8:0] transmit_shift_register;
   logic [8:0] buffered_word;
   logic [3:0] tx_bits;
   logic shift_clock;
   logic last_bit;
   assign tx_on = serial_port_enable && clocked_mode && master_clock_source
      && transmit_enable;
   assign tx_write = wr_hit(OFS_TRANSMIT_DATA);
   assign tx_busy = !shift_register_empty;
   assign last_bit = tx_bits == (tx_control[NINE_BIT_TRANSMIT_BIT] ? BITS_NINE : BITS_EIGHT)
      - 4'h1;
   // reload only when idle or right after the last bit's high phase
   assign tx_load = tx_on && buffer_full && !rx_state[1] && !rx_state[2] && !rx_state[3]
      && ((tx_state == TX_IDLE) || (tx_state == TX_HIGH && baud_tick && last_bit));

   always_ff @(posedge REF_CLK or posedge RESET) begin
      if (RESET) begin
         transmit_data <= RESET_BYTE;
         buffered_word <= 9'h000;
      end else if (tx_write) begin
         transmit_data <= DAT_I[7:0];
         buffered_word <= {tx_control[TRANSMIT_NINTH_BIT], DAT_I[7:0]};
      end
   end

   always_ff @(posedge REF_CLK or posedge RESET) begin
      if (RESET)
         buffer_full <= 1'b0;
      else if (!tx_on)
         buffer_full <= 1'b0;
      else if (tx_write)
         buffer_full <= 1'b1;
      else if (tx_load)
         buffer_full <= 1'b0;
   end

   // empty flag: set on enable and on each transfer, cleared by a data write
   // or while transmit is disabled; flag register writes never reach it
   always_ff @(posedge REF_CLK or posedge RESET) begin
      if (RESET) begin
         tx_en_prev <= 1'b0;
         transmit_buffer_empty_flag <= 1'b0;
      end else begin
         tx_en_prev <= transmit_enable;
         if (!transmit_enable)
            transmit_buffer_empty_flag <= 1'b0;
         else if (tx_write)
            transmit_buffer_empty_flag <= 1'b0;
         else if (transmit_enable && !tx_en_prev)
            transmit_buffer_empty_flag <= 1'b1;
         else if (tx_load)
            transmit_buffer_empty_flag <= 1'b1;
      end
   end

   // the shifter has no address; only the pin sees its contents
   always_ff @(posedge REF_CLK or posedge RESET) begin
      if (RESET) begin
         tx_state <= TX_IDLE;
         transmit_shift_register <= 9'h000;
         tx_bits <= 4'h0;
         shift_clock <= 1'b0;
         shift_register_empty <= 1'b1;
      end else if (!tx_on) begin
         tx_state <= TX_IDLE;
         shift_clock <= 1'b0;
         shift_register_empty <= 1'b1;
      end else if (tx_load) begin
         transmit_shift_register <= buffered_word;
         tx_bits <= 4'h0;
         shift_clock <= 1'b0;
         shift_register_empty <= 1'b0;
         tx_state <= TX_LOW;
      end else begin
         case (tx_state)
            TX_IDLE: shift_clock <= 1'b0;
            TX_LOW: begin
               if (baud_tick) begin
                  shift_clock <= 1'b1;
                  tx_state <= TX_HIGH;
               end
            end
            TX_HIGH: begin
               if (baud_tick) begin
                  shift_clock <= 1'b0;
                  if (last_bit) begin
                     shift_register_empty <= 1'b1;
                     tx_state <= TX_IDLE;
                  end else begin
                     transmit_shift_register <= {1'b0, transmit_shift_register[8:1]};
                     tx_bits <= tx_bits + 4'h1;
                     tx_state <= TX_LOW;
                  end
               end
            end
            default: tx_state <= TX_IDLE;
         endcase
      end
   end

   // ----------------------------------------------------------------------
   // pins and interrupt outputs
   // ----------------------------------------------------------------------
   // data changes while the clock is low, so it is stable at the rising edge
   logic port_sync_master;
   assign port_sync_master = serial_port_enable && clocked_mode && master_clock_source;
   always_ff @(posedge REF_CLK or posedge RESET) begin
      if (RESET) begin
         SHIFT_TIMING_LINE_OUT <= 1'b0;
         SHIFT_TIMING_LINE_OE <= 1'b0;
         SERIAL_DATA_LINE_OUT <= 1'b0;
         SERIAL_DATA_LINE_OE <= 1'b0;
      end else begin
         SHIFT_TIMING_LINE_OUT <= shift_clock;
         SHIFT_TIMING_LINE_OE <= port_sync_master;
         SERIAL_DATA_LINE_OUT <= transmit_shift_register[0];
         SERIAL_DATA_LINE_OE <= port_sync_master && transmit_enable;
      end
   end

   logic rx_pending;
   logic tx_pending;
   logic global_interrupt_enable;
   assign global_interrupt_enable = interrupt_control[GLOBAL_INTERRUPT_ENABLE_BIT];
   assign rx_pending = receive_complete_flag && peripheral_enables_one[RECEIVE_BIT];
   assign tx_pending = transmit_buffer_empty_flag
      && peripheral_enables_one[TRANSMIT_BIT];
   always_ff @(posedge REF_CLK or posedge RESET) begin
      if (RESET) begin
         INTERRUPT_HIGH <= 1'b0;
         INTERRUPT_LOW <= 1'b0;
      end else begin
         INTERRUPT_HIGH <= global_interrupt_enable && ((rx_pending && peripheral_priorities_one[RECEIVE_BIT])
            || (tx_pending && peripheral_priorities_one[TRANSMIT_BIT]));
         INTERRUPT_LOW <= global_interrupt_enable && ((rx_pending && !peripheral_priorities_one[RECEIVE_BIT])
            || (tx_pending && !peripheral_priorities_one[TRANSMIT_BIT]));
      end
   end
endmodule

// ---- sim/usart_assertions.sv ----
/* Checker on the core's ports.
 Assumes a bind from the bench top. */
`timescale 1ns/1ps
module usart_assertions(
   input wire logic REF_CLK, RESET, CYC_I, STB_I, ACK_O,
   input wire logic [31:0] DAT_O,
   input wire logic SHIFT_TIMING_LINE_OUT, SHIFT_TIMING_LINE_OE,
   input wire logic SERIAL_DATA_LINE_OUT, SERIAL_DATA_LINE_OE
);
   default clocking @(posedge REF_CLK); endclocking
   default disable iff (RESET);
   sequence bus_req; CYC_I && STB_I && !ACK_O; endsequence
   sequence one_ack; ACK_O ##1 !ACK_O; endsequence
   ack_once_a: assert property (bus_req |=> one_ack) else $error("ack not one cycle");
   ack_idle_a: assert property (!(CYC_I && STB_I) |=> !ACK_O) else $error("ack unasked");
   ack_cause_a: assert property (ACK_O |-> $past(CYC_I && STB_I)) else $error("ack no cause");
   read_width_a: assert property (ACK_O |-> DAT_O[31:8] == 24'h000000) else $error("upper bits");
   clk_driven_a: assert property (SHIFT_TIMING_LINE_OUT |-> SHIFT_TIMING_LINE_OE)
      else $error("clock undriven");
   data_hold_a: assert property (SHIFT_TIMING_LINE_OUT && $past(SHIFT_TIMING_LINE_OUT)
      |-> $stable(SERIAL_DATA_LINE_OUT)) else $error("data moved high");
   rise_tx_a: assert property ($rose(SHIFT_TIMING_LINE_OUT) |-> SERIAL_DATA_LINE_OE)
      else $error("clock without data");
   data_low_a: assert property (!$stable(SERIAL_DATA_LINE_OUT) && SERIAL_DATA_LINE_OE
      |-> !SHIFT_TIMING_LINE_OUT) else $error("data edge in high");
endmodule

// ---- sim/usart_far_node.sv ----
/* Far side: async node sending frames, sync slave capturing words.
 Assumes the bench resolves the pins. */
`timescale 1ns/1ps
module usart_far_node(
   input wire logic clk,
   input wire logic sck,
   input wire logic sdat,
   output logic rx_line
);
   logic [15:0] cap = 16'h0000;
   initial rx_line = 1'b1;
   // sample on rising clock; data was set while low
   always @(posedge sck) cap <= {sdat, cap[15:1]};
   // start, nine bits lsb first, stop; 16 cycles a bit
   task automatic send(input logic [8:0] w);
      logic [10:0] f;
      f = {1'b1, w, 1'b0};
      for (int i = 0; i < 11; i++) begin
         rx_line <= f[i];
         repeat (16) @(posedge clk);
      end
   endtask
endmodule

// ---- sim/testbench.sv ----
/* Bench: sync master transmit and address-detect receive.
 Assumes the far node model and the checker. */
`timescale 1ns/1ps
`define CHK(a, b) begin tests_run++; if ((a) !== (b)) begin errors++; \
   $display("[ERR] %0t %h %h", $time, a, b); end end
module testbench;
   import usart_pkg::*;
   logic clk = 0, rst = 1, cyc = 0, stb = 0, we = 0;
   logic [7:0] adr = 8'h00, q;
   logic [31:0] dat = 32'h0, dat_o;
   logic ack, sck_o, sck_oe, sd_o, sd_oe, rx, irq_h, irq_l;
   wire sck = sck_oe ? sck_o : 1'b0;
   wire sd = sd_oe ? sd_o : rx;
   int errors = 0, tests_run = 0;
   usart_core i_usart_core(.REF_CLK(clk), .RESET(rst), .CYC_I(cyc), .STB_I(stb), .WE_I(we),
      .ADR_I(adr), .SEL_I(4'hF), .DAT_I(dat), .DAT_O(dat_o), .ACK_O(ack),
      .SHIFT_TIMING_LINE_IN(sck), .SHIFT_TIMING_LINE_OUT(sck_o), .SHIFT_TIMING_LINE_OE(sck_oe),
      .SERIAL_DATA_LINE_IN(sd), .SERIAL_DATA_LINE_OUT(sd_o), .SERIAL_DATA_LINE_OE(sd_oe),
      .INTERRUPT_HIGH(irq_h), .INTERRUPT_LOW(irq_l));
   usart_far_node i_usart_far_node(.clk(clk), .sck(sck), .sdat(sd), .rx_line(rx));
   initial forever #5 clk = ~clk;
   task automatic wb(input logic w, input logic [7:0] a, input logic [7:0] d);
      @(posedge clk);
      {cyc, stb, we, adr, dat} <= {1'b1, 1'b1, w, a, 24'h0, d};
      // no cycle limit here: only the watchdog ends a hung request
      do begin @(posedge clk); end while (ack !== 1'b1);
      q = dat_o[7:0];
      {cyc, stb} <= 2'b00;
   endtask
   task automatic rd(input logic [7:0] a, input logic [7:0] e);
      wb(1'b0, a, 8'h00);
      `CHK(q, e)
   endtask
   task automatic reset_values;
      rd(OFS_TRANSMIT_STATUS_CONTROL, TRANSMIT_STATUS_RESET);
      rd(OFS_PERIPHERAL_FLAGS_ONE, RESET_BYTE);
      rd(8'h24, 8'h00);
   endtask
   task automatic sync_transmit;
      // divisor 1 keeps each clock phase two cycles long
      wb(1'b1, OFS_BAUD_DIVISOR, 8'h01);
      wb(1'b1, OFS_RECEIVE_STATUS_CONTROL, 8'h80);
      wb(1'b1, OFS_TRANSMIT_STATUS_CONTROL, 8'hB0);
      rd(OFS_PERIPHERAL_FLAGS_ONE, 8'h10);
      `CHK({irq_h, irq_l}, 2'b00)
      wb(1'b1, OFS_TRANSMIT_DATA, 8'hA5);
      wb(1'b1, OFS_TRANSMIT_DATA, 8'h5A);
      rd(OFS_PERIPHERAL_FLAGS_ONE, 8'h00);
      rd(OFS_TRANSMIT_STATUS_CONTROL, 8'hB0);
      for (int i = 0; i < 40 && q[1] !== 1'b1; i++) wb(1'b0, OFS_TRANSMIT_STATUS_CONTROL, 8'h00);
      `CHK(q, 8'hB2)
      `CHK(i_usart_far_node.cap, 16'h5AA5)
      wb(1'b1, OFS_PERIPHERAL_FLAGS_ONE, 8'h00);
      rd(OFS_PERIPHERAL_FLAGS_ONE, 8'h10);
      // nine-bit word: all-zero data with a one in the ninth bit
      wb(1'b1, OFS_TRANSMIT_STATUS_CONTROL, 8'hF1);
      wb(1'b1, OFS_TRANSMIT_DATA, 8'h00);
      q = 8'h00;
      for (int i = 0; i < 40 && q[1] !== 1'b1; i++) wb(1'b0, OFS_TRANSMIT_STATUS_CONTROL, 8'h00);
      `CHK(q, 8'hF3)
      `CHK(i_usart_far_node.cap, 16'h802D)
   endtask
   task automatic addr_receive;
      wb(1'b1, OFS_BAUD_DIVISOR, 8'h00);
      wb(1'b1, OFS_TRANSMIT_STATUS_CONTROL, 8'h04);
      wb(1'b1, OFS_PERIPHERAL_ENABLES_ONE, 8'h20);
      wb(1'b1, OFS_PERIPHERAL_PRIORITIES_ONE, 8'h20);
      wb(1'b1, OFS_INTERRUPT_CONTROL, 8'h80);
      wb(1'b1, OFS_RECEIVE_STATUS_CONTROL, 8'hC8);
      wb(1'b1, OFS_RECEIVE_STATUS_CONTROL, 8'hD8);
      i_usart_far_node.send(9'h055);
      rd(OFS_PERIPHERAL_FLAGS_ONE, 8'h00);
      `CHK({irq_h, irq_l}, 2'b00)
      i_usart_far_node.send(9'h13C);
      rd(OFS_PERIPHERAL_FLAGS_ONE, 8'h20);
      `CHK({irq_h, irq_l}, 2'b10)
      rd(OFS_RECEIVE_STATUS_CONTROL, 8'hD9);
      rd(OFS_RECEIVE_DATA, 8'h3C);
      wb(1'b1, OFS_RECEIVE_STATUS_CONTROL, 8'hD0);
      i_usart_far_node.send(9'h055);
      rd(OFS_RECEIVE_DATA, 8'h55);
   endtask
   task automatic summarize;
      $display("errors=%0d tests_run=%0d", errors, tests_run);
      if (errors == 0 && tests_run > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask
   initial begin
      repeat (16) @(posedge clk);
      rst <= 1'b0;
      reset_values;
      sync_transmit;
      addr_receive;
      summarize;
   end
   initial begin
      #500000;
      errors++;
      summarize;
   end
endmodule
bind usart_core usart_assertions i_usart_assertions(.REF_CLK(REF_CLK), .RESET(RESET),
   .CYC_I(CYC_I), .STB_I(STB_I), .ACK_O(ACK_O), .DAT_O(DAT_O),
   .SHIFT_TIMING_LINE_OUT(SHIFT_TIMING_LINE_OUT), .SHIFT_TIMING_LINE_OE(SHIFT_TIMING_LINE_OE),
   .SERIAL_DATA_LINE_OUT(SERIAL_DATA_LINE_OUT), .SERIAL_DATA_LINE_OE(SERIAL_DATA_LINE_OE));
